//--- fcd_pkg.sv
// Shared constants for the coefficient download link.
`default_nettype none
package fcd_pkg;
    // ---------------------------------------------------------------
    // Word framing
    // ---------------------------------------------------------------
    localparam int          BCAST_BIT      = 31;
    localparam int          DADDR_HI       = 30;
    localparam int          DADDR_LO       = 28;
    localparam int          SIGN_BIT       = 26;
    localparam int          REG_ADDR_LO    = 16;
    localparam logic [11:0] REG_ADDR_CTL1  = 12'h001;
    localparam logic [15:0] CTL1_RESET     = 16'h001A;
    localparam int          CTL_ARM_BIT    = 15;
    localparam int          CTL_RDSTAT_BIT = 11;
    localparam int          CTL_FLEN_LO    = 5;
    localparam int          CTL_DEC_LO     = 0;
    localparam logic [15:0] CTL_SELFCLR    = 16'hFE00;
    localparam int          STAT_DLOK_BIT  = 7;
    localparam int          MAX_COEFFS     = 48;
    localparam int          COEFFS_PER_STEP = 6;
    // ---------------------------------------------------------------
    // Timing: half a master-clock period per unused slot, at 100 MHz
    // ---------------------------------------------------------------
    localparam int          CLK_PERIOD_PS  = 10000;
    localparam int          FILL_SLOT_PS   = CLK_PERIOD_PS / 2;
    localparam int          FILL_SLOT_CYC  =
        (FILL_SLOT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // ---------------------------------------------------------------
    // Host register map over Wishbone
    // ---------------------------------------------------------------
    localparam logic [3:0]  HREG_CTRL      = 4'h0;
    localparam logic [3:0]  HREG_COEF      = 4'h4;
    localparam logic [3:0]  HREG_STAT      = 4'h8;
    localparam logic [3:0]  HREG_RESULT    = 4'hC;
endpackage
`default_nettype wire

//--- fcd_link_if.sv
// Word link between the host controller and the device.
`default_nettype none
interface fcd_link_if;
    logic        word_valid;
    logic [31:0] word_data;
    logic        word_ready;
    logic        stat_valid;
    logic [15:0] stat_data;
    modport host (output word_valid, output word_data, input word_ready,
                  input stat_valid, input stat_data);
    modport device (input word_valid, input word_data, output word_ready,
                    output stat_valid, output stat_data);
endinterface
`default_nettype wire

//--- fcd_device.sv
// Device end: register writes, coefficient download, checksum and zero-fill.
`default_nettype none
module fcd_device (
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    // Link to host
    fcd_link_if.device       link,
    // Pins and observed state
    input  wire logic [2:0]  ADDR_PINS_I,
    output logic      [15:0] CONTROL_ONE_O,
    output logic      [15:0] STATUS_O,
    output logic             LOADING_O
);
    typedef enum logic [1:0] {ST_REG, ST_COEF, ST_FILL} fcd_state_e;

    fcd_state_e  state_q;
    logic [15:0] ctl_q;
    logic [15:0] sum_q;
    logic [5:0]  idx_q;
    logic [5:0]  ncoef_q;
    logic        dlok_q;
    logic        stv_q;
    logic [26:0] coef_q [fcd_pkg::MAX_COEFFS];
    logic        hit;
    logic        take;
    logic [15:0] byte_sum;
    logic [3:0]  flen;
    logic [5:0]  ncoef_d;

    // ---------------------------------------------------------------
    // Word decode
    // ---------------------------------------------------------------
    assign hit = link.word_data[fcd_pkg::BCAST_BIT] ||
        (link.word_data[fcd_pkg::DADDR_HI:fcd_pkg::DADDR_LO] == ADDR_PINS_I);
    assign take = link.word_valid && link.word_ready && hit;
    assign byte_sum = 16'(link.word_data[31:24]) + 16'(link.word_data[23:16])
        + 16'(link.word_data[15:8]) + 16'(link.word_data[7:0]);
    assign flen = link.word_data[fcd_pkg::CTL_FLEN_LO +: 4];
    // Half the taps: odd codes n give (n+1)/2 steps of six coefficients.
    assign ncoef_d = (flen == 4'h0) ? 6'h00 :
        6'((({2'h0, flen} + 6'h01) >> 1) * fcd_pkg::COEFFS_PER_STEP);

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            state_q <= ST_REG;
            idx_q   <= 6'h00;
            ncoef_q <= 6'h00;
            sum_q   <= 16'h0000;
        end else begin
            case (state_q)
                ST_REG: begin
                    if (take && link.word_data[27:16] == fcd_pkg::REG_ADDR_CTL1 &&
                        link.word_data[fcd_pkg::CTL_ARM_BIT] && ncoef_d != 6'h00) begin
                        state_q <= ST_COEF;
                        ncoef_q <= ncoef_d;
                        idx_q   <= 6'h00;
                        sum_q   <= 16'h0000;
                    end
                end
                ST_COEF: begin
                    if (take) begin
                        if (idx_q == ncoef_q) begin
                            // Slots above the loaded set are all cleared in the first fill cycle; fill lasts one cycle per slot.
                            state_q <= ST_FILL;
                        end else begin
                            sum_q <= sum_q + byte_sum;
                            idx_q <= idx_q + 6'h01;
                        end
                    end
                end
                ST_FILL: begin
                    if (idx_q >= 6'(fcd_pkg::MAX_COEFFS - 1)) begin
                        state_q <= ST_REG;
                    end
                    idx_q <= idx_q + 6'h01;
                end
                default: state_q <= ST_REG;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Coefficient store, one generate entry per slot
    // ---------------------------------------------------------------
    for (genvar g = 0; g < fcd_pkg::MAX_COEFFS; g++) begin : g_coef
        always_ff @(posedge CLOCK_I) begin
            if (RST_I) begin
                coef_q[g] <= 27'h0000000;
            end else if (state_q == ST_COEF && take && idx_q == 6'(g) &&
                         idx_q != ncoef_q) begin
                coef_q[g] <= link.word_data[fcd_pkg::SIGN_BIT:0];
            end else if (state_q == ST_FILL && idx_q <= 6'(g)) begin
                coef_q[g] <= 27'h0000000;
            end
        end
    end

    // ---------------------------------------------------------------
    // Control register and download flag
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            ctl_q <= fcd_pkg::CTL1_RESET;
        end else if (state_q == ST_REG && take &&
                     link.word_data[27:16] == fcd_pkg::REG_ADDR_CTL1) begin
            ctl_q <= link.word_data[15:0];
        end else begin
            ctl_q <= ctl_q & ~fcd_pkg::CTL_SELFCLR;
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            dlok_q <= 1'b0;
        end else if (state_q == ST_REG && take &&
                     link.word_data[27:16] == fcd_pkg::REG_ADDR_CTL1 &&
                     link.word_data[fcd_pkg::CTL_ARM_BIT]) begin
            dlok_q <= 1'b0;
        end else if (state_q == ST_COEF && take && idx_q == ncoef_q) begin
            dlok_q <= (link.word_data[15:0] == sum_q) &&
                      (link.word_data[27:16] == 12'h000);
        end
    end

    // Status readback: a control write with the read-status bit answers once.
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            stv_q <= 1'b0;
        end else begin
            stv_q <= state_q == ST_REG && take &&
                     link.word_data[27:16] == fcd_pkg::REG_ADDR_CTL1 &&
                     link.word_data[fcd_pkg::CTL_RDSTAT_BIT];
        end
    end

    // Words are refused during zero-fill, which enforces the wait on the host.
    assign link.word_ready = (state_q != ST_FILL);
    assign link.stat_valid = stv_q;
    assign link.stat_data  = STATUS_O;

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            CONTROL_ONE_O <= fcd_pkg::CTL1_RESET;
            STATUS_O      <= 16'h0000;
            LOADING_O     <= 1'b0;
        end else begin
            CONTROL_ONE_O <= ctl_q;
            STATUS_O      <= 16'(dlok_q) << fcd_pkg::STAT_DLOK_BIT;
            LOADING_O     <= (state_q != ST_REG);
        end
    end
endmodule
`default_nettype wire

//--- fcd_host.sv
// Host end: Wishbone slave that forwards words and captures status.
`default_nettype none
module fcd_host (
    // Clock and reset
    input  wire logic        CLOCK_I,
    input  wire logic        RST_I,
    // Wishbone slave
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [3:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    // Link to device
    fcd_link_if.host         link
);
    logic        req;
    logic [31:0] word_q;
    logic        valid_q;
    logic [15:0] stat_q;
    logic        stat_new_q;
    logic [15:0] csum_q;

    assign req = CYC_I && STB_I && !ACK_O;
    assign link.word_valid = valid_q;
    assign link.word_data  = word_q;

    // ---------------------------------------------------------------
    // Word sender
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            valid_q <= 1'b0;
            word_q  <= 32'h00000000;
        end else if (valid_q) begin
            // Stall until the device leaves zero-fill.
            if (link.word_ready) begin
                valid_q <= 1'b0;
            end
        end else if (req && WE_I && SEL_I == 4'hF &&
                     (ADR_I == fcd_pkg::HREG_CTRL || ADR_I == fcd_pkg::HREG_COEF)) begin
            valid_q <= 1'b1;
            word_q  <= DAT_I;
        end
    end

    // Running checksum of coefficient writes, readable for software.
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            csum_q <= 16'h0000;
        end else if (req && WE_I && !valid_q && ADR_I == fcd_pkg::HREG_CTRL) begin
            csum_q <= 16'h0000;
        end else if (req && WE_I && !valid_q && ADR_I == fcd_pkg::HREG_COEF) begin
            csum_q <= csum_q + 16'(DAT_I[31:24]) + 16'(DAT_I[23:16])
                + 16'(DAT_I[15:8]) + 16'(DAT_I[7:0]);
        end
    end

    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            stat_q     <= 16'h0000;
            stat_new_q <= 1'b0;
        end else if (link.stat_valid) begin
            stat_q     <= link.stat_data;
            stat_new_q <= 1'b1;
        end else if (req && !WE_I && ADR_I == fcd_pkg::HREG_RESULT) begin
            stat_new_q <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Bus answer
    // ---------------------------------------------------------------
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h00000000;
        end else begin
            ACK_O <= req && !(WE_I && valid_q);
            case (ADR_I)
                fcd_pkg::HREG_STAT:   DAT_O <= {15'h0000, stat_new_q, csum_q};
                fcd_pkg::HREG_RESULT: DAT_O <= {16'h0000, stat_q};
                default:              DAT_O <= 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

//--- fcd_link_assertions.sv
// Checker for the word link between the host end and the device end.
`default_nettype none
module fcd_link_assertions (
    // Clock and reset
    input wire logic        CLOCK_I,
    input wire logic        RST_I,
    // Link signals
    input wire logic        word_valid,
    input wire logic [31:0] word_data,
    input wire logic        word_ready,
    input wire logic        stat_valid,
    input wire logic [15:0] stat_data
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    // ---------------------------------------------------------------
    // Shadow of the download sequence, for device address 000.
    // ---------------------------------------------------------------
    logic        take;
    logic        reg1;
    logic        arm;
    logic        cks;
    logic        rd;
    logic [5:0]  left_q;
    logic [5:0]  fill_q;
    logic [15:0] sum_q;
    logic        ok_q;
    assign take = word_valid && word_ready && (word_data[31] || word_data[30:28] == 3'h0);
    assign reg1 = take && left_q == 6'h00 && word_data[27:16] == 12'h001;
    assign arm  = reg1 && word_data[15] && word_data[8:5] != 4'h0;
    assign cks  = take && left_q == 6'h01;
    assign rd   = reg1 && word_data[11];
    always_ff @(posedge CLOCK_I) begin
        if (RST_I) begin
            left_q <= 6'h00;
            fill_q <= 6'h00;
        end else if (arm) begin
            left_q <= ({3'h0, word_data[8:6]} + 6'h01) * 6'h06 + 6'h01;
            fill_q <= 6'h30 - ({3'h0, word_data[8:6]} + 6'h01) * 6'h06;
        end else if (take && left_q != 6'h00) begin
            left_q <= left_q - 6'h01;
        end
    end
    always_ff @(posedge CLOCK_I) begin
        if (RST_I || arm) begin
            sum_q <= 16'h0000;
            ok_q  <= 1'b0;
        end else if (cks) begin
            ok_q <= sum_q == word_data[15:0];
        end else if (take && left_q > 6'h01) begin
            sum_q <= sum_q + 16'(word_data[31:24]) + 16'(word_data[23:16])
                     + 16'(word_data[15:8]) + 16'(word_data[7:0]);
        end
    end
    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    sequence s_take; word_valid && word_ready; endsequence
    sequence s_fill; !word_ready [*8]; endsequence
    property p_hold; word_valid && !word_ready |=> word_valid && $stable(word_data); endproperty
    property p_drop; s_take |=> !word_valid; endproperty
    property p_pulse; stat_valid |=> !stat_valid; endproperty
    property p_answer; rd |=> stat_valid; endproperty
    property p_cause; stat_valid |-> $past(rd); endproperty
    property p_dlok; stat_valid |-> stat_data[7] == ok_q; endproperty
    property p_fill_low; cks && fill_q >= 6'h08 |-> ##2 s_fill; endproperty
    property p_fill_end; cks |-> ##[1:60] word_ready; endproperty
    a_hold: assert property (p_hold) else $error("word changed before taken");
    a_drop: assert property (p_drop) else $error("word offered twice");
    a_pulse: assert property (p_pulse) else $error("status pulse too long");
    a_answer: assert property (p_answer) else $error("status not returned");
    a_cause: assert property (p_cause) else $error("status not requested");
    a_dlok: assert property (p_dlok) else $error("download flag wrong");
    a_fill_low: assert property (p_fill_low) else $error("fill too short");
    a_fill_end: assert property (p_fill_end) else $error("fill never ends");
endmodule
`default_nettype wire

//--- fir_coefficient_download_test.sv
// Testbench for the coefficient download through the host and device ends.
`default_nettype none
module fir_coefficient_download_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst;
    logic        cyc;
    logic        we;
    logic [3:0]  adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] got;
    logic        ack;
    logic [15:0] ctl;
    logic [15:0] stat;
    logic        loading;
    int          n_errors;
    int          samples_checked;
    logic [31:0] coef [12] = '{32'h032B9688, 32'h01BF183C, 32'h00156626, 32'h04A81E6A,
                               32'h045F2A96, 32'h002C49C2, 32'h0050E9F6, 32'h0010DBD8,
                               32'h042FDE54, 32'h0437445A, 32'h041B7D6E, 32'h04043B5F};
    fcd_link_if link ();
    fcd_host i_fcd_host (.CLOCK_I(clk), .RST_I(rst), .CYC_I(cyc), .STB_I(cyc), .WE_I(we),
        .ADR_I(adr), .SEL_I(4'hF), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack), .link(link));
    fcd_device i_fcd_device (.CLOCK_I(clk), .RST_I(rst), .link(link), .ADDR_PINS_I(3'h0),
        .CONTROL_ONE_O(ctl), .STATUS_O(stat), .LOADING_O(loading));
    fcd_link_assertions i_fcd_link_assertions (.CLOCK_I(clk), .RST_I(rst),
        .word_valid(link.word_valid), .word_data(link.word_data),
        .word_ready(link.word_ready), .stat_valid(link.stat_valid),
        .stat_data(link.stat_data));
    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 200);
        // Read data is taken at the edge that saw the acknowledge.
        got = rdat;
        if (t >= 200) begin
            n_errors++;
        end
        cyc <= 1'b0;
    endtask
    task automatic conclude();
        $display("checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        chk("control reset", 32'(ctl), 32'h001A);
        chk("status reset", 32'(stat), 32'h0000);
    endtask
    // The sign and magnitude set that the host sends must sum to the unity gain value.
    task automatic t_scale();
        int acc;
        acc = 0;
        for (int i = 0; i < 12; i++) begin
            if (coef[i][26]) begin
                acc = acc - int'(coef[i][25:0]);
            end else begin
                acc = acc + int'(coef[i][25:0]);
            end
        end
        chk("coefficient sum", 32'(acc), 32'h03FFFFFF);
    endtask
    // An arm with length code zero keeps the built-in filter and register mode.
    task automatic t_default();
        wb(1'b1, fcd_pkg::HREG_CTRL, 32'h0001801A);
        repeat (4) @(posedge clk);
        chk("default kept", 32'(loading), 32'h0);
        chk("arm cleared", 32'(ctl), 32'h001A);
    endtask
    // A full 24-tap load; the fill of 36 slots stalls the status request.
    task automatic t_load(input logic [15:0] sum, input logic ok);
        wb(1'b1, fcd_pkg::HREG_CTRL, 32'h0001807A);
        for (int i = 0; i < 12; i++) begin
            wb(1'b1, fcd_pkg::HREG_COEF, coef[i]);
        end
        wb(1'b0, fcd_pkg::HREG_STAT, 32'h0);
        chk("byte sum", 32'(got[15:0]), 32'h0E6B);
        chk("loading", 32'(loading), 32'h1);
        wb(1'b1, fcd_pkg::HREG_COEF, {16'h0000, sum});
        wb(1'b1, fcd_pkg::HREG_CTRL, 32'h0001087A);
        // The status request waits in the host until the zero-fill is over.
        for (int n = 0; n < 40 && got[16] !== 1'b1; n++) begin
            wb(1'b0, fcd_pkg::HREG_STAT, 32'h0);
        end
        chk("status new", 32'(got[16]), 32'h1);
        wb(1'b0, fcd_pkg::HREG_RESULT, 32'h0);
        chk("download ok", 32'(got[7]), 32'(ok));
        chk("control kept", 32'(ctl), 32'h007A);
        chk("loading done", 32'(loading), 32'h0);
    endtask
    task automatic t_address();
        wb(1'b1, fcd_pkg::HREG_CTRL, 32'h10010073);
        repeat (4) @(posedge clk);
        chk("other address", 32'(ctl), 32'h007A);
        wb(1'b1, fcd_pkg::HREG_CTRL, 32'h80010073);
        repeat (4) @(posedge clk);
        chk("broadcast", 32'(ctl), 32'h0073);
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end
    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        we = 1'b0;
        adr = 4'h0;
        wdat = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_scale();
        t_load(16'h0E6B, 1'b1);
        t_address();
        t_load(16'h0E6C, 1'b0);
        t_default();
        conclude();
    end
endmodule
`default_nettype wire
